// [inc/codec_glue_pkg.sv]
package codec_glue_pkg;

   // =====================================================
   // clock tree ratios
   localparam int MCLK_DIV        = 4;
   localparam int BCLK_DIV        = 64;
   localparam int FRAME_BITCLKS   = 16;
   localparam int FS_HIGH_BITCLKS = 8;
   localparam int DELAY_STAGES    = 2;

   // =====================================================
   // sample formats
   localparam int BYTE_BITS    = 8;
   localparam int LIN_W        = 16;
   localparam int IN_W         = 14;
   localparam int MAG_W        = 13;
   localparam int SEG_W        = 3;
   localparam int QUANT_W      = 4;
   localparam int SEG_BASE_BIT = 5;

   // =====================================================
   // companding constants
   localparam logic [13:0] MU_BIAS    = 14'h001f;
   localparam logic [15:0] EXP_BIAS   = 16'h0021;
   localparam logic [12:0] MAG_MAX    = 13'h1fff;
   localparam logic [6:0]  CODE_SAT   = 7'h7f;
   localparam logic [7:0]  IDLE_LINE  = 8'hff;

   // serial port states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } port_state_e;

endpackage

// [core/shift_delay.sv]
`timescale 1ns/1ps
// =====================================================
// fixed delay line of flip-flops
module shift_delay #(
   parameter int DEPTH = 8
) (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_d,
   output logic      o_q
);

   logic [DEPTH-1:0] sh_q;

   if (DEPTH < 2) begin : g_chk
      $error("shift_delay needs at least two stages");
   end

   // each master clock stage is several core stages here
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sh_q <= '0;
      end else begin
         sh_q <= {sh_q[DEPTH-2:0], i_d};
      end
   end

   assign o_q = sh_q[DEPTH-1];

endmodule

// [core/codec_serial_glue_mulaw.sv]
`timescale 1ns/1ps
// =====================================================
// codec clock generation, slave serial port, mu-law
module codec_serial_glue_mulaw
   import codec_glue_pkg::*;
#(
   parameter int P_MCLK_DIV  = MCLK_DIV,
   parameter int P_BCLK_DIV  = BCLK_DIV,
   parameter int P_FRAME     = FRAME_BITCLKS,
   parameter int P_FS_HIGH   = FS_HIGH_BITCLKS,
   parameter int P_DELAY_STG = DELAY_STAGES
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_codec_dx,
   input  wire logic [IN_W-1:0]  i_tx_sample,
   output logic                  o_codec_master_clock,
   output logic                  o_codec_bit_clock,
   output logic                  o_transmit_frame_sync,
   output logic                  o_receive_frame_sync,
   output logic                  o_serial_shift_clock,
   output logic                  o_codec_dr,
   output logic [BYTE_BITS-1:0]  o_rx_code,
   output logic [LIN_W-1:0]      o_rx_sample,
   output logic                  o_rx_valid
);

   // =====================================================
   // derived sizes
   localparam int MW       = $clog2(P_MCLK_DIV);
   localparam int BW       = $clog2(P_BCLK_DIV);
   localparam int FW       = $clog2(P_FRAME);
   localparam int DLY      = P_DELAY_STG * P_MCLK_DIV;
   localparam int FRAME_CY = P_FRAME * P_BCLK_DIV;
   localparam int GAP_W    = $clog2(FRAME_CY) + 1;
   localparam logic [FW-1:0] FRAME_LAST = FW'(P_FRAME - 1);
   localparam logic [FW-1:0] FS_HIGH    = FW'(P_FS_HIGH);
   localparam logic [2:0]    LAST_BIT   = 3'(BYTE_BITS - 1);

   // a delay of half a bit clock or more would swallow the burst
   if ((1 << MW) != P_MCLK_DIV || (1 << BW) != P_BCLK_DIV ||
       (1 << FW) != P_FRAME || P_MCLK_DIV < 2 ||
       P_BCLK_DIV <= P_MCLK_DIV || P_FS_HIGH != BYTE_BITS ||
       DLY >= P_BCLK_DIV / 2 || P_DELAY_STG < 1) begin : g_chk
      $error("codec_serial_glue_mulaw: unsupported parameters");
   end

   // =====================================================
   // clock divider and frame timer
   logic [BW-1:0] prescale_q;
   logic [BW-1:0] prescale_d;
   logic          mclk_q;
   logic          bclk_q;
   logic          bclk_d;
   logic          bclk_rise_w;
   logic [FW-1:0] frame_cnt_q;
   logic [FW-1:0] frame_cnt_d;
   logic          fs_q;
   logic          fs_d;
   logic          fs_rise_w;
   logic          burst_w;
   logic          sk_w;
   logic          sk_prev_q;
   logic          sk_rise_w;
   logic          sk_fall_w;

   // both codec clocks tap one counter, so they stay locked
   assign prescale_d  = prescale_q + 1'b1;
   assign bclk_d      = prescale_d[BW-1];
   assign bclk_rise_w = bclk_d & ~bclk_q;
   assign frame_cnt_d = bclk_rise_w ? frame_cnt_q + 1'b1
                                    : frame_cnt_q;
   assign fs_d        = (frame_cnt_d < FS_HIGH);
   assign fs_rise_w   = fs_d & ~fs_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         prescale_q  <= '0;
         mclk_q      <= 1'b1;
         bclk_q      <= 1'b0;
         frame_cnt_q <= FRAME_LAST;
         fs_q        <= 1'b0;
      end else begin
         prescale_q  <= prescale_d;
         mclk_q      <= ~prescale_d[MW-1];
         bclk_q      <= bclk_d;
         frame_cnt_q <= frame_cnt_d;
         fs_q        <= fs_d;
      end
   end

   assign o_codec_master_clock  = mclk_q;
   assign o_codec_bit_clock     = bclk_q;
   assign o_transmit_frame_sync = fs_q;
   assign o_receive_frame_sync  = fs_q;

   // =====================================================
   // shift clock: gated bit clock, delayed by master clocks
   assign burst_w = bclk_q & fs_q;

   shift_delay #(
      .DEPTH (DLY)
   ) u_sk_delay (
      .i_clk   (i_core_clk),
      .i_rst_b (i_rst_b),
      .i_d     (burst_w),
      .o_q     (sk_w)
   );

   assign o_serial_shift_clock = sk_w;

   // edge detect on our own shift clock, not on a pin
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         sk_prev_q <= 1'b0;
      end else begin
         sk_prev_q <= sk_w;
      end
   end

   assign sk_rise_w = sk_w & ~sk_prev_q;
   assign sk_fall_w = ~sk_w & sk_prev_q;

   // =====================================================
   // compression of the transmit sample
   logic                 tx_sign_w;
   logic [IN_W-1:0]      tx_abs_w;
   logic [MAG_W-1:0]     tx_mag_w;
   logic [IN_W-1:0]      tx_biased_w;
   logic [SEG_W-1:0]     tx_seg_w;
   logic [MAG_W-1:0]     tx_norm_w;
   logic [BYTE_BITS-1:0] tx_code_w;

   // position of the leading one, bits below the base share seg 0
   function automatic logic [SEG_W-1:0] seg_of(input logic [MAG_W-1:0] v);
      logic [SEG_W-1:0] s;
      s = '0;
      for (int i = SEG_BASE_BIT; i < MAG_W; i++) begin
         if (v[i]) begin
            s = SEG_W'(i - SEG_BASE_BIT);
         end
      end
      return s;
   endfunction

   assign tx_sign_w   = i_tx_sample[IN_W-1];
   assign tx_abs_w    = tx_sign_w ? (~i_tx_sample + 1'b1) : i_tx_sample;
   // full-scale negative has no 13-bit magnitude, clip it
   assign tx_mag_w    = tx_abs_w[IN_W-1] ? MAG_MAX
                                         : tx_abs_w[MAG_W-1:0];
   assign tx_biased_w = {1'b0, tx_mag_w} + MU_BIAS;
   assign tx_seg_w    = seg_of(tx_biased_w[MAG_W-1:0]);
   assign tx_norm_w   = tx_biased_w[MAG_W-1:0] >> tx_seg_w;
   assign tx_code_w   = tx_biased_w[IN_W-1]
                        ? {tx_sign_w, CODE_SAT}
                        : {tx_sign_w, tx_seg_w,
                           tx_norm_w[QUANT_W:1]};

   // =====================================================
   // expansion of the received code
   logic [BYTE_BITS-1:0] rx_byte_w;
   logic [BYTE_BITS-1:0] rx_sh_q;
   logic [LIN_W-1:0]     exp_step_w;
   logic [LIN_W-1:0]     exp_mag_w;
   logic [LIN_W-1:0]     exp_lin_w;

   // codec sends the inverted code
   assign rx_byte_w  = ~{rx_sh_q[BYTE_BITS-2:0], i_codec_dx};
   // table entry ((2q+33) << seg) - 33, negated for the upper half
   assign exp_step_w = {11'h000, rx_byte_w[3:0], 1'b0} + EXP_BIAS;
   assign exp_mag_w  = (exp_step_w << rx_byte_w[6:4]) - EXP_BIAS;
   assign exp_lin_w  = rx_byte_w[BYTE_BITS-1] ? (~exp_mag_w + 1'b1)
                                              : exp_mag_w;

   // =====================================================
   // slave serial port
   port_state_e          state_q;
   port_state_e          state_d;
   logic [BYTE_BITS-1:0] tx_sh_q;
   logic [2:0]           bit_cnt_q;
   logic                 done_w;
   logic                 rx_valid_q;
   logic [BYTE_BITS-1:0] rx_code_q;
   logic [LIN_W-1:0]     rx_sample_q;

   assign done_w = (state_q == ST_SHIFT) && sk_rise_w &&
                   (bit_cnt_q == LAST_BIT);

   // a frame start always restarts the port, even mid-byte
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (fs_rise_w) begin
               state_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (fs_rise_w) begin
               state_d = ST_SHIFT;
            end else if (done_w) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= '0;
         rx_sh_q   <= '0;
      end else begin
         state_q <= state_d;
         if (fs_rise_w) begin
            bit_cnt_q <= '0;
         end else if (state_q == ST_SHIFT && sk_rise_w) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
            rx_sh_q   <= {rx_sh_q[BYTE_BITS-2:0], i_codec_dx};
         end
      end
   end

   // transmit byte loads at frame start, moves on falling edges
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         tx_sh_q <= IDLE_LINE;
      end else if (fs_rise_w) begin
         tx_sh_q <= ~tx_code_w;
      end else if (state_q == ST_SHIFT && sk_fall_w) begin
         tx_sh_q <= {tx_sh_q[BYTE_BITS-2:0], 1'b1};
      end
   end

   assign o_codec_dr = tx_sh_q[BYTE_BITS-1];

   // received results held until the next byte completes
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         rx_valid_q  <= 1'b0;
         rx_code_q   <= '0;
         rx_sample_q <= '0;
      end else begin
         rx_valid_q <= done_w;
         if (done_w) begin
            rx_code_q   <= rx_byte_w;
            rx_sample_q <= exp_lin_w;
         end
      end
   end

   assign o_rx_valid  = rx_valid_q;
   assign o_rx_code   = rx_code_q;
   assign o_rx_sample = rx_sample_q;

   // =====================================================
   // checks
   localparam int A_MCLK  = P_MCLK_DIV;
   localparam int A_BCLK  = P_BCLK_DIV;
   localparam int A_DLY   = DLY;

   logic [GAP_W-1:0] gap_q;
   logic             seen_q;

   // cycles since the last frame start
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= fs_rise_w ? '0 : gap_q + 1'b1;
         seen_q <= seen_q | fs_rise_w;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   a_mclk_rate: assert property (
      $rose(o_codec_master_clock) |-> ##A_MCLK
      $rose(o_codec_master_clock))
      else $error("master clock period wrong");
   a_bclk_rate: assert property (
      $rose(o_codec_bit_clock) |-> ##A_BCLK $rose(o_codec_bit_clock))
      else $error("bit clock period wrong");
   a_clock_align: assert property (
      $rose(o_codec_bit_clock) |-> $rose(o_codec_master_clock))
      else $error("master and bit clock edges apart");
   a_fs_edge: assert property (
      $rose(o_transmit_frame_sync) |-> $rose(o_codec_bit_clock))
      else $error("frame sync off bit clock edge");
   a_frame_period: assert property (
      fs_rise_w && seen_q |-> gap_q == GAP_W'(FRAME_CY - 1))
      else $error("frame period wrong");
   a_fs_shared: assert property (
      o_transmit_frame_sync == o_receive_frame_sync)
      else $error("frame syncs differ");
   a_sk_delay: assert property (
      $rose(burst_w) |-> ##A_DLY $rose(o_serial_shift_clock))
      else $error("shift clock delay wrong");
   a_sk_burst: assert property (
      $rose(o_serial_shift_clock) |-> $past(o_transmit_frame_sync, A_DLY))
      else $error("shift clock outside frame");
   a_rx_byte: assert property (
      done_w |=> o_rx_valid && o_rx_code == ~$past(
      {rx_sh_q[BYTE_BITS-2:0], i_codec_dx}))
      else $error("received code not captured inverted");
   a_tx_fall: assert property (
      state_q == ST_SHIFT && sk_fall_w && !fs_rise_w
      |=> o_codec_dr == $past(tx_sh_q[BYTE_BITS-2]))
      else $error("transmit bit not advanced on fall");
   a_tx_hold: assert property (
      sk_rise_w && !fs_rise_w |=> $stable(o_codec_dr))
      else $error("transmit bit moved on rise");
   a_tx_sign: assert property (
      fs_rise_w |=> o_codec_dr == ~$past(i_tx_sample[IN_W-1]))
      else $error("code sign bit wrong");
   a_tx_sat: assert property (
      fs_rise_w && tx_biased_w[IN_W-1]
      |=> tx_sh_q[BYTE_BITS-2:0] == ~CODE_SAT)
      else $error("overflow not saturated");
   a_exp_sign: assert property (
      o_rx_valid |-> (o_rx_code[BYTE_BITS-1] ?
      !o_rx_sample[LIN_W-1] == (o_rx_sample == '0) :
      !o_rx_sample[LIN_W-1]))
      else $error("expanded sign wrong");

   c_rx_byte:  cover property (o_rx_valid);
   c_tx_sat:   cover property (fs_rise_w && tx_biased_w[IN_W-1]);
   c_tx_neg:   cover property (fs_rise_w && tx_sign_w);
   c_rx_neg:   cover property (o_rx_valid && o_rx_code[BYTE_BITS-1]);

endmodule

// [verif/codec_model.sv]
`timescale 1ns/1ps
// =====================================================
// codec side: long frame sync, one byte each way a frame
module codec_model (
   input  wire logic       i_bclk,
   input  wire logic       i_fs,
   input  wire logic       i_dr,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_dx,
   output logic [7:0]      o_rx_byte,
   output logic            o_rx_done
);
   int         tx_n  = 8;
   int         rx_n  = 8;
   logic       fs_q  = 1'b0;
   logic [7:0] sh_tx = 8'h00;
   logic [7:0] sh_rx = 8'h00;

   initial begin
      o_dx = 1'b0;
      o_rx_byte = 8'h00;
      o_rx_done = 1'b0;
   end

   // look a moment after the edge: fs and bclk switch in the same step
   always @(posedge i_bclk) begin
      #1;
      if (i_fs && !fs_q) begin
         sh_tx = i_tx_byte;
         tx_n = 0;
         rx_n = 0;
      end
      fs_q = i_fs;
      if (tx_n < 8) begin
         o_dx = sh_tx[7 - tx_n];
         tx_n++;
      end else begin
         o_dx = ~o_dx; // released line, never a steady last bit
      end
   end

   // receive bits on the trailing edges, msb first
   always @(negedge i_bclk) begin
      #1;
      o_rx_done = 1'b0;
      if (rx_n < 8) begin
         sh_rx = {sh_rx[6:0], i_dr};
         rx_n++;
         if (rx_n == 8) begin
            o_rx_byte = sh_rx;
            o_rx_done = 1'b1;
         end
      end
   end
endmodule

// [verif/test_codec_serial_glue_mulaw.sv]
`timescale 1ns/1ps
// =====================================================
// bench: clock tree watch, sample traffic both ways
module test_codec_serial_glue_mulaw
   import codec_glue_pkg::*;
;
   localparam int NF    = 24;
   localparam int LIMIT = 30000;

   logic        clk = 1'b0;
   logic        rst_b;
   logic [13:0] smp;
   logic [7:0]  cbyte;
   logic        mclk, bclk, fs, rfs, sk, dr, dx, rx_valid, rx_done;
   logic [7:0]  rx_code, rx_byte;
   logic [15:0] rx_sample;
   logic [7:0]  exp_tx[$];
   logic [23:0] exp_rx[$];
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          mc_n, bc_n, sk_d, bits, sk_n;
   logic        mc_p, bc_p, fs_p, sk_p;
   logic [13:0] edge_smp [8] = '{14'h0000, 14'h1fff, 14'h2000, 14'h3fff,
                                 14'h1fe0, 14'h1fe1, 14'h0001, 14'h0021};
   logic [7:0]  edge_byte [4] = '{8'hff, 8'h00, 8'h80, 8'h7f};

   always #25 clk = ~clk;

   codec_serial_glue_mulaw dut (
      .i_core_clk           (clk),
      .i_rst_b              (rst_b),
      .i_codec_dx           (dx),
      .i_tx_sample          (smp),
      .o_codec_master_clock (mclk),
      .o_codec_bit_clock    (bclk),
      .o_transmit_frame_sync(fs),
      .o_receive_frame_sync (rfs),
      .o_serial_shift_clock (sk),
      .o_codec_dr           (dr),
      .o_rx_code            (rx_code),
      .o_rx_sample          (rx_sample),
      .o_rx_valid           (rx_valid)
   );

   codec_model codec (
      .i_bclk   (bclk),
      .i_fs     (fs),
      .i_dr     (dr),
      .i_tx_byte(cbyte),
      .o_dx     (dx),
      .o_rx_byte(rx_byte),
      .o_rx_done(rx_done)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // reference compressor: clip, bias, segment by leading one
   function automatic logic [7:0] compress(input logic [13:0] s);
      logic [13:0] mag;
      logic [13:0] b;
      logic [13:0] sh;
      logic [2:0]  seg;
      mag = s[13] ? (~s + 14'h0001) : s;
      if (mag > {1'b0, MAG_MAX}) mag = {1'b0, MAG_MAX};
      b = mag + MU_BIAS;
      seg = 3'h0;
      for (int p = 6; p <= 12; p++) if (b[p]) seg = 3'(p - 5);
      sh = b >> seg;
      if (b > {1'b0, MAG_MAX}) return {s[13], 7'h7f};
      return {s[13], seg, sh[4:1]};
   endfunction

   // reference expander built like the table: start and step double per seg
   function automatic logic [15:0] expand(input logic [7:0] c);
      logic [15:0] sv;
      logic [15:0] inc;
      logic [15:0] m;
      sv = 16'h0021;
      inc = 16'h0002;
      for (int g = 0; g < int'(c[6:4]); g++) begin
         sv = sv << 1;
         inc = inc << 1;
      end
      m = sv - 16'h0021 + inc * c[3:0];
      return c[7] ? (~m + 16'h0001) : m;
   endfunction

   // driver: new sample and codec byte while frame sync is low
   initial begin
      rst_b = 1'b0;
      smp = edge_smp[0];
      cbyte = edge_byte[0];
      void'($urandom(32'ha657));
      repeat (6) @(posedge clk);
      // reset levels: master clock high, shift clock idle, line idle high
      #2 chk({mclk, bclk, fs, sk, dr, rx_valid}, 6'b100010);
      #3 rst_b = 1'b1;
      for (int f = 1; f <= NF; f++) begin
         @(posedge fs);
         exp_tx.push_back(~compress(smp));
         exp_rx.push_back({~cbyte, expand(~cbyte)});
         @(negedge fs);
         @(posedge clk);
         #5;
         smp = (f < 8) ? edge_smp[f] : 14'($urandom());
         cbyte = (f < 4) ? edge_byte[f] : 8'($urandom());
      end
      repeat (4) @(posedge clk);
      // every noted byte must have been seen by now
      chk(exp_rx.size(), 0);
      chk(exp_tx.size(), 0);
      stop_test();
   end

   // clock tree watch; first edges after reset are not timed
   always @(posedge clk) begin
      #2;
      if (rst_b !== 1'b1) begin
         mc_n = 1000;
         bc_n = 1000;
         bits = 1000;
         sk_n = 1000;
         sk_d = 0;
      end else begin
         mc_n++;
         bc_n++;
         sk_d++;
         if (mclk === 1'b1 && mc_p === 1'b0) begin
            if (mc_n < 500) chk(mc_n, 4);
            mc_n = 0;
         end
         if (bclk === 1'b1 && bc_p === 1'b0) begin
            if (bc_n < 500) chk(bc_n, 64);
            chk({mclk, mc_p}, 2'b10);
            bc_n = 0;
            sk_d = 0;
            bits++;
         end
         if (sk === 1'b1 && sk_p === 1'b0) begin
            chk(sk_d, 8);
            sk_n++;
         end
         if (fs !== fs_p) chk(rfs, fs);
         if (fs === 1'b1 && fs_p === 1'b0) begin
            chk({bclk, bc_p}, 2'b10);
            if (bits < 500) chk(bits, 16);
            if (sk_n < 500) chk(sk_n, 8);
            bits = 0;
            sk_n = 0;
         end
      end
      mc_p = mclk;
      bc_p = bclk;
      fs_p = fs;
      sk_p = sk;
   end

   // receive side of the block: oldest note per valid pulse
   always @(posedge clk) begin
      logic [23:0] e;
      #2;
      if (rx_valid === 1'b1) begin
         if (exp_rx.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            e = exp_rx.pop_front();
            chk(rx_code, e[23:16]);
            chk(rx_sample, e[15:0]);
         end
      end
   end

   // byte seen by the codec model
   always @(posedge rx_done) begin
      if (exp_tx.size() == 0) begin
         chk(32'h1, 32'h0);
      end else begin
         chk(rx_byte, exp_tx.pop_front());
      end
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         stop_test();
      end
   end
endmodule
